// file: src/cisu_top.sv
// interrupt entry/exit logic and 16-entry hardware return stack
//---------------------------------------------------------------------
// Notes on behaviour
// - handler entry address held in 16-bit vector, reset to zero.
// - no interrupt taken unless global enable bit is one.
// - source requests only when module mask and local enable set.
// - on acceptance set in-service, block others, jump to vector.
// - one shared handler; ident bit n shows module n pending.
// - ident bits ignore writes; drop only when module flag clears.
// - unconditional interrupt return clears in-service, jumps to pop.
// - software may clear mask bits and in-service to allow nesting.
// - mask zero suppresses request only; ident bit still shows.
// - true conditional return pops, clears flag, jumps; false: nothing.
// - stack entries are 16 bits; used by call, returns, push, pop.
// - push increments pointer then stores; 16-bit source stored whole.
// - 8-bit push stores prefix as high byte, source as low byte.
// - pop reads current entry then decrements pointer.
// - pop-and-release is a pop that also clears in-service.
// - popped value offered directly as an operand to the ALU.
// - 16 words; 4-bit pointer resets to 0fh; writable by software.
// - prefix supplies upper byte of 8-bit branch destinations.
//---------------------------------------------------------------------
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cisu_top #(
   parameter int NMOD = 8
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [4:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   // peripheral module flags (already masked by local enables)
   input  wire logic [NMOD-1:0]       modIrqIn,
   // instruction sequencer
   input  wire cisu_pkg::cisu_seq_req_t seqReq,
   input  wire logic                  irqAck,
   output logic                       irqReq,
   output logic                       jumpValid,
   output logic      [15:0]           jumpAddr,
   output logic      [15:0]           aluOperand,
   output logic                       inService
);
   //------------------------------------------------------------------
   // storage
   //------------------------------------------------------------------
   logic [15:0]     vector_ff;
   logic            gie_ff;
   logic            ins_ff;
   logic [NMOD-1:0] mask_ff;
   logic [NMOD-1:0] pendS1_ff;
   logic [NMOD-1:0] pend_ff;
   logic [7:0]      prefix_ff;
   logic [3:0]      sptr_ff;
   logic [15:0]     stack_ff [16];
   logic            irqReq_ff;
   logic            jumpValid_ff;
   logic [15:0]     jumpAddr_ff;
   logic [15:0]     aluOp_ff;
   logic            ack_ff;
   logic [31:0]     rdat_ff;

   //------------------------------------------------------------------
   // request decode
   //------------------------------------------------------------------
   // helpers shared by the processes below
   logic        wbReq;
   logic        wbWr;
   logic        condTrue;
   logic        doPush;
   logic        doPop;
   logic        clrIns;
   logic        take;
   logic [15:0] pushVal;
   logic [15:0] topVal;
   logic [3:0]  sptrInc;
   logic [3:0]  sptrDec;
   logic [3:0]  nxt_sptr;
   logic        pageStk;
   logic [3:0]  regOff;

   // a write lands on the edge at which the master samples ack, so the
   // register and the answer change together
   assign wbReq   = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wbWr    = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0];
   assign pageStk = wb_adr_i[4];
   assign regOff  = wb_adr_i[3:0];
   assign topVal  = stack_ff[sptr_ff];       // read before decrement
   assign sptrInc = sptr_ff + 4'h1;          // wraps silently
   assign sptrDec = sptr_ff - 4'h1;          // wraps silently

   // condition evaluation for conditional interrupt returns
   always_comb begin
      case (seqReq.cond)
         cisu_pkg::CND_C:  condTrue = seqReq.flags.carry;
         cisu_pkg::CND_NC: condTrue = ~seqReq.flags.carry;
         cisu_pkg::CND_Z:  condTrue = seqReq.flags.zero;
         cisu_pkg::CND_NZ: condTrue = ~seqReq.flags.zero;
         cisu_pkg::CND_S:  condTrue = seqReq.flags.sign;
         default:          condTrue = 1'b0;
      endcase
   end

   // accepting an interrupt pushes the return address given on data
   assign take = irqReq_ff & irqAck;

   // stack operation selection
   always_comb begin
      doPush  = 1'b0;
      doPop   = 1'b0;
      clrIns  = 1'b0;
      pushVal = seqReq.data;                 // whole 16-bit value
      case (seqReq.op)
         cisu_pkg::OP_PUSH16, cisu_pkg::OP_CALL: begin
            doPush = 1'b1;
         end
         cisu_pkg::OP_PUSH8: begin
            doPush  = 1'b1;
            pushVal = {prefix_ff, seqReq.data[7:0]};
         end
         cisu_pkg::OP_POP, cisu_pkg::OP_RET: begin
            doPop = 1'b1;
         end
         cisu_pkg::OP_POPI, cisu_pkg::OP_RETI: begin
            doPop  = 1'b1;
            clrIns = 1'b1;
         end
         cisu_pkg::OP_RETI_COND: begin
            doPop  = condTrue;               // false leaves all alone
            clrIns = condTrue;
         end
         default: begin
            doPush = 1'b0;
         end
      endcase
      // an accepted interrupt overrides the op that rides along with it
      if (take) begin
         doPush  = 1'b1;                     // entry saves return address
         doPop   = 1'b0;
         pushVal = seqReq.data;
      end
   end

   // pointer next value: explicit write, then push, then pop
   // a sequencer SETSP beats a bus write in the same cycle; a bus write beats push and pop
   always_comb begin
      nxt_sptr = sptr_ff;
      if (seqReq.op == cisu_pkg::OP_SETSP && !take) begin
         nxt_sptr = seqReq.data[3:0];        // only low four bits
      end else if (wbWr && pageStk && regOff == cisu_pkg::ADDR_SPTR) begin
         nxt_sptr = wb_dat_i[3:0];
      end else if (doPush) begin
         nxt_sptr = sptrInc;                 // increment first
      end else if (doPop) begin
         nxt_sptr = sptrDec;                 // decrement after read
      end
   end

   //------------------------------------------------------------------
   // stack pointer and stack memory
   //------------------------------------------------------------------
   // pointer resets to the top entry
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sptr_ff <= cisu_pkg::SPTR_RST;
      end else begin
         sptr_ff <= nxt_sptr;
      end
   end

   // memory is not reset; contents are undefined until pushed
   // leaving out the reset lets the array map onto plain ram cells
   always_ff @(posedge clk) begin
      if (doPush) begin
         stack_ff[sptrInc] <= pushVal;       // store at new slot
      end
   end

   //------------------------------------------------------------------
   // module flag synchroniser and identification
   //------------------------------------------------------------------
   // flags come from peripherals possibly on other clocks
   // two stages; nothing but the second stage reads the first
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pendS1_ff <= '0;
         pend_ff   <= '0;
      end else begin
         pendS1_ff <= modIrqIn;
         pend_ff   <= pendS1_ff;             // follows module flag only
      end
   end

   //------------------------------------------------------------------
   // control registers
   //------------------------------------------------------------------
   // vector register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vector_ff <= cisu_pkg::VECTOR_RST;
      end else if (wbWr && !pageStk && regOff == cisu_pkg::ADDR_VECTOR) begin
         vector_ff[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) begin
            vector_ff[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // global enable and mask; mask may be lowered in a handler
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gie_ff  <= 1'b0;
         mask_ff <= '0;
      end else if (wbWr && !pageStk) begin
         if (regOff == cisu_pkg::ADDR_CTRL) begin
            gie_ff <= wb_dat_i[cisu_pkg::CTRL_GIE_BIT];
         end
         if (regOff == cisu_pkg::ADDR_MASK) begin
            mask_ff <= wb_dat_i[NMOD-1:0];
         end
      end
   end

   // in-service: hardware set wins over any clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ins_ff <= 1'b0;
      end else if (take) begin
         ins_ff <= 1'b1;                     // blocks further requests
      end else if (clrIns) begin
         ins_ff <= 1'b0;
      end else if (wbWr && !pageStk && regOff == cisu_pkg::ADDR_CTRL) begin
         ins_ff <= wb_dat_i[cisu_pkg::CTRL_INS_BIT]; // nesting
      end
   end

   // prefix register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prefix_ff <= cisu_pkg::PREFIX_RST;
      end else if (wbWr && pageStk && regOff == cisu_pkg::ADDR_PREFIX) begin
         prefix_ff <= wb_dat_i[7:0];
      end
   end

   //------------------------------------------------------------------
   // interrupt request
   //------------------------------------------------------------------
   // take and clrIns squash the request in the cycle that in-service
   // changes, so a stale request can never meet a second acknowledge
   // masked pending only stops the request, not the ident bit
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irqReq_ff <= 1'b0;
      end else begin
         irqReq_ff <= gie_ff & ~ins_ff & ~take & ~clrIns
                      & |(pend_ff & mask_ff);
      end
   end

   //------------------------------------------------------------------
   // branch target and operand outputs
   //------------------------------------------------------------------
   // vector on entry, popped address on returns, prefix for 8-bit
   // pop and pop-and-release move data only and give no jump
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         jumpValid_ff <= 1'b0;
         jumpAddr_ff  <= 16'h0000;
      end else if (take) begin
         jumpValid_ff <= 1'b1;
         jumpAddr_ff  <= vector_ff;          // single handler
      end else if (doPop && seqReq.op != cisu_pkg::OP_POP
                   && seqReq.op != cisu_pkg::OP_POPI) begin
         jumpValid_ff <= 1'b1;
         jumpAddr_ff  <= topVal;
      end else if (seqReq.op == cisu_pkg::OP_JUMP8) begin
         jumpValid_ff <= 1'b1;
         jumpAddr_ff  <= {prefix_ff, seqReq.data[7:0]};
      end else begin
         jumpValid_ff <= 1'b0;
      end
   end

   // popped word goes straight to the alu, no register file hop
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         aluOp_ff <= 16'h0000;
      end else if (doPop) begin
         aluOp_ff <= topVal;
      end
   end

   //------------------------------------------------------------------
   // wishbone read path
   //------------------------------------------------------------------
   // one wait state; unmapped offsets read zero and still ack
   // read data is zeroed each cycle so it reads zero while ack is low
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff  <= wbReq;
         rdat_ff <= 32'h00000000;
         if (wbReq && !pageStk) begin
            case (regOff)
               cisu_pkg::ADDR_VECTOR: rdat_ff[15:0] <= vector_ff;
               cisu_pkg::ADDR_CTRL: begin
                  rdat_ff[cisu_pkg::CTRL_GIE_BIT] <= gie_ff;
                  rdat_ff[cisu_pkg::CTRL_INS_BIT] <= ins_ff;
               end
               cisu_pkg::ADDR_MASK:  rdat_ff[NMOD-1:0] <= mask_ff;
               cisu_pkg::ADDR_IDENT: rdat_ff[NMOD-1:0] <= pend_ff;
               default:              rdat_ff <= 32'h00000000;
            endcase
         end else if (wbReq) begin
            case (regOff)
               cisu_pkg::ADDR_PREFIX: rdat_ff[7:0] <= prefix_ff;
               cisu_pkg::ADDR_SPTR:   rdat_ff[3:0] <= sptr_ff;
               default:               rdat_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // each output is a flip-flop with no logic after it
   assign wb_ack_o   = ack_ff;
   assign wb_dat_o   = rdat_ff;
   assign irqReq     = irqReq_ff;
   assign jumpValid  = jumpValid_ff;
   assign jumpAddr   = jumpAddr_ff;
   assign aluOperand = aluOp_ff;
   assign inService  = ins_ff;
endmodule
`default_nettype wire

// file: src/cisu_pkg.sv
// package of constants and types for the interrupt and stack unit
package cisu_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses on the wishbone bus)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_VECTOR  = 4'h0;
   localparam logic [3:0] ADDR_CTRL    = 4'h4;
   localparam logic [3:0] ADDR_MASK    = 4'h8;
   localparam logic [3:0] ADDR_IDENT   = 4'hc;
   localparam logic [3:0] ADDR_PREFIX  = 4'h0;
   localparam logic [3:0] ADDR_SPTR    = 4'h4;
   localparam logic       PAGE_IRQ     = 1'b0;
   localparam logic       PAGE_STACK   = 1'b1;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_GIE_BIT  = 0;
   localparam int CTRL_INS_BIT  = 1;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] VECTOR_RST = 16'h0000;
   localparam logic [3:0]  SPTR_RST   = 4'hf;
   localparam logic [7:0]  PREFIX_RST = 8'h00;
   // ---------------------------------------------------------------
   // sequencer operations and return conditions
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE, OP_PUSH16, OP_PUSH8, OP_POP, OP_POPI, OP_CALL,
      OP_RET, OP_RETI, OP_RETI_COND, OP_JUMP8, OP_SETSP
   } cisu_op_t;
   typedef enum logic [2:0] {
      CND_C, CND_NC, CND_Z, CND_NZ, CND_S
   } cisu_cond_t;
   // processor flags seen by the conditional returns
   typedef struct packed {
      logic carry;
      logic zero;
      logic sign;
   } cisu_flags_t;
   // one request from the instruction sequencer
   typedef struct packed {
      cisu_op_t    op;
      cisu_cond_t  cond;
      cisu_flags_t flags;
      logic [15:0] data;
   } cisu_seq_req_t;
endpackage

// file: testbench/cisu_props.sv
// assertion checker bound to the interrupt and stack unit
`timescale 1ns/1ps
`default_nettype none
module cisu_props #(
   parameter int NMOD = 8
) (
   // clock and reset
   input wire logic                    clk,
   input wire logic                    rst_b,
   // wishbone slave
   input wire logic                    wb_cyc_i,
   input wire logic                    wb_stb_i,
   input wire logic                    wb_we_i,
   input wire logic [4:0]              wb_adr_i,
   input wire logic [3:0]              wb_sel_i,
   input wire logic [31:0]             wb_dat_i,
   input wire logic [31:0]             wb_dat_o,
   input wire logic                    wb_ack_o,
   // peripheral flags and sequencer
   input wire logic [NMOD-1:0]         modIrqIn,
   input wire cisu_pkg::cisu_seq_req_t seqReq,
   input wire logic                    irqAck,
   input wire logic                    irqReq,
   input wire logic                    jumpValid,
   input wire logic [15:0]             jumpAddr,
   input wire logic [15:0]             aluOperand,
   input wire logic                    inService
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // true when a conditional return would fire on these flags
   function automatic logic condHit(input cisu_pkg::cisu_seq_req_t r);
      case (r.cond)
         cisu_pkg::CND_C:  condHit = r.flags.carry;
         cisu_pkg::CND_NC: condHit = !r.flags.carry;
         cisu_pkg::CND_Z:  condHit = r.flags.zero;
         cisu_pkg::CND_NZ: condHit = !r.flags.zero;
         cisu_pkg::CND_S:  condHit = r.flags.sign;
         default:          condHit = 1'b0;
      endcase
   endfunction
   // an op that is not overridden by an interrupt entry
   sequence s_op(cisu_pkg::cisu_op_t o);
      seqReq.op == o && !irqAck;
   endsequence
   sequence s_push_pop;
      s_op(cisu_pkg::OP_PUSH16) ##1 s_op(cisu_pkg::OP_POP);
   endsequence
   sequence s_push_ret;
      s_op(cisu_pkg::OP_PUSH16) ##1 s_op(cisu_pkg::OP_RET);
   endsequence
   a_ins_on_ack: assert property (
      irqReq && irqAck |=> inService && jumpValid && !irqReq)
      else $error("interrupt entry did not set in service");
   a_req_blocked_ins: assert property (
      inService && $past(inService) |-> !irqReq)
      else $error("request raised while in service");
   a_reti_clears_ins: assert property (
      s_op(cisu_pkg::OP_RETI) |=> !inService && jumpValid)
      else $error("interrupt return left in service set");
   a_popi_clears_ins: assert property (
      s_op(cisu_pkg::OP_POPI) |=> !inService && !jumpValid)
      else $error("pop and release misbehaved");
   a_cond_true_ret: assert property (
      seqReq.op == cisu_pkg::OP_RETI_COND && !irqAck && condHit(seqReq)
      |=> jumpValid && !inService)
      else $error("true conditional return did not return");
   a_cond_false_hold: assert property (
      seqReq.op == cisu_pkg::OP_RETI_COND && !irqAck && !condHit(seqReq)
      |=> !jumpValid && $stable(inService))
      else $error("false conditional return changed state");
   a_push_pop_value: assert property (
      s_push_pop |=> aluOperand == $past(seqReq.data, 2))
      else $error("popped word differs from pushed word");
   a_push_ret_target: assert property (
      s_push_ret |=> jumpAddr == $past(seqReq.data, 2))
      else $error("return target differs from pushed word");
endmodule
bind cisu_top cisu_props #(.NMOD(NMOD)) u_cisu_props (
   .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .modIrqIn(modIrqIn), .seqReq(seqReq), .irqAck(irqAck), .irqReq(irqReq),
   .jumpValid(jumpValid), .jumpAddr(jumpAddr), .aluOperand(aluOperand),
   .inService(inService)
);
`default_nettype wire

// file: testbench/cisu_peri_model.sv
// model of the peripheral modules that raise interrupt flags
`timescale 1ns/1ps
`default_nettype none
module cisu_peri_model #(
   parameter int NMOD = 8
) (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst_b,
   // flag commands from the bench
   input  wire logic [NMOD-1:0] setFlag,
   input  wire logic [NMOD-1:0] clrFlag,
   input  wire logic [NMOD-1:0] localEn,
   // requests towards the unit
   output logic      [NMOD-1:0] modIrqOut
);
   logic [NMOD-1:0] flag_ff;
   // a flag stays up until the handler clears it inside its module
   always_ff @(posedge clk) begin
      if (!rst_b)
         flag_ff <= '0;
      else
         flag_ff <= (flag_ff | setFlag) & ~clrFlag;
   end
   // the local enable gates the flag before it leaves the module
   assign modIrqOut = flag_ff & localEn;
endmodule
`default_nettype wire

// file: testbench/cisu_top_tb.sv
// self-checking bench for the interrupt and stack unit
`timescale 1ns/1ps
`default_nettype none
module cisu_top_tb;
   localparam int NMOD = 8;
   logic                    clk = 1'h0;
   logic                    rst_b = 1'h0;
   logic                    wbReq = 1'h0;
   logic                    wbWe = 1'h0;
   logic [4:0]              wbAdr = 5'h00;
   logic [31:0]             wbDat = 32'h0;
   logic [31:0]             wbDatO;
   logic                    wbAck;
   logic [31:0]             rdq;
   logic [NMOD-1:0]         setFlag = '0;
   logic [NMOD-1:0]         clrFlag = '0;
   logic [NMOD-1:0]         localEn = '0;
   logic [NMOD-1:0]         modIrq;
   cisu_pkg::cisu_seq_req_t seqReq = '0;
   logic                    irqAck = 1'h0;
   logic                    irqReq;
   logic                    jumpValid;
   logic [15:0]             jumpAddr;
   logic [15:0]             aluOperand;
   logic                    inService;
   logic [31:0]             seed = 32'h11;
   int                      mismatches = 0;
   int                      nChecks = 0;
   always #10 clk = ~clk;
   cisu_top #(.NMOD(NMOD)) u_cisu_top (
      .clk(clk), .rst_b(rst_b), .wb_cyc_i(wbReq), .wb_stb_i(wbReq),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .modIrqIn(modIrq),
      .seqReq(seqReq), .irqAck(irqAck), .irqReq(irqReq),
      .jumpValid(jumpValid), .jumpAddr(jumpAddr), .aluOperand(aluOperand),
      .inService(inService));
   cisu_peri_model #(.NMOD(NMOD)) u_cisu_peri_model (
      .clk(clk), .rst_b(rst_b), .setFlag(setFlag), .clrFlag(clrFlag),
      .localEn(localEn), .modIrqOut(modIrq));
   // xorshift keeps the random data repeatable
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   function automatic cisu_pkg::cisu_seq_req_t mk(input cisu_pkg::cisu_op_t o,
      input logic [15:0] d, input logic [2:0] c = 3'h0,
      input logic [2:0] f = 3'h0);
      mk = {o, c, f, d};
   endfunction
   // flags all set fire c, z, s; all clear fire nc, nz
   function automatic logic condExp(input int c, input int f);
      logic [4:0] m;
      m = f[0] ? 5'h15 : 5'h0a;
      return m[c];
   endfunction
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      nChecks++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   // one classic cycle; the request holds until ack is sampled high
   task automatic wb(input logic we, input logic [4:0] a,
                     input logic [31:0] d);
      int i;
      @(posedge clk);
      wbReq <= 1'h1;
      wbWe <= we;
      wbAdr <= a;
      wbDat <= d;
      for (i = 0; i < 20 && wbAck !== 1'h1; i++)
         @(posedge clk);
      rdq = wbDatO;
      wbReq <= 1'h0;
      if (i == 20) begin
         mismatches++;
         endOfTest();
      end
   endtask
   task automatic step(input cisu_pkg::cisu_seq_req_t r, input logic a);
      @(posedge clk);
      seqReq <= r;
      irqAck <= a;
   endtask
   // results of the previous op are settled after this
   task automatic idle();
      step(mk(cisu_pkg::OP_NONE, 16'h0), 1'h0);
      #1;
   endtask
   task automatic pulse(input logic [NMOD-1:0] s, input logic [NMOD-1:0] c);
      @(posedge clk);
      setFlag <= s;
      clrFlag <= c;
      @(posedge clk);
      setFlag <= '0;
      clrFlag <= '0;
   endtask
   initial begin
      #1000000;
      mismatches++;
      endOfTest();
   end
   initial begin
      logic [15:0] v, a, x, y;
      logic [7:0]  p;
      int          c, f;
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      wb(1'h0, 5'h00, 32'h0);
      chk("vector", rdq[15:0], 16'h0);
      wb(1'h0, 5'h14, 32'h0);
      chk("sptr", rdq[3:0], 4'hf);
      v = rnd();
      a = rnd();
      p = a[7:0];
      wb(1'h1, 5'h00, {16'h0, v});
      wb(1'h1, 5'h10, {24'h0, p});
      wb(1'h0, 5'h00, 32'h0);
      chk("vector", rdq[15:0], v);
      wb(1'h1, 5'h0c, 32'hff);
      wb(1'h0, 5'h0c, 32'h0);
      chk("ident", rdq[7:0], 8'h0);
      wb(1'h0, 5'h18, 32'h0);
      chk("unmapped", rdq, 32'h0);
      // pending seen with global enable off, then with its mask bit off
      localEn <= 8'hff;
      wb(1'h1, 5'h08, 32'hff);
      pulse(8'h04, 8'h0);
      repeat (5) @(posedge clk);
      chk("reqGieOff", irqReq, 1'h0);
      wb(1'h1, 5'h08, 32'hfb);
      wb(1'h1, 5'h04, 32'h1);
      repeat (5) @(posedge clk);
      chk("reqMasked", irqReq, 1'h0);
      wb(1'h0, 5'h0c, 32'h0);
      chk("identMasked", rdq[7:0], 8'h04);
      localEn <= 8'hfb;
      wb(1'h1, 5'h08, 32'hff);
      repeat (5) @(posedge clk);
      chk("reqLocalOff", irqReq, 1'h0);
      localEn <= 8'hff;
      for (c = 0; c < 10 && irqReq !== 1'h1; c++)
         @(posedge clk);
      chk("irqReq", irqReq, 1'h1);
      a = rnd();
      step(mk(cisu_pkg::OP_NONE, a), 1'h1);
      idle();
      chk("entry", {jumpValid, jumpAddr, inService}, {1'h1, v, 1'h1});
      repeat (4) @(posedge clk);
      chk("blocked", irqReq, 1'h0);
      pulse(8'h0, 8'h04);
      repeat (4) @(posedge clk);
      wb(1'h0, 5'h0c, 32'h0);
      chk("identDrop", rdq[7:0], 8'h0);
      step(mk(cisu_pkg::OP_RETI, 16'h0), 1'h0);
      idle();
      chk("reti", {jumpValid, jumpAddr, inService}, {1'h1, a, 1'h0});
      // stack wraps both ways; 8-bit push takes the prefix as high byte
      x = rnd();
      y = rnd();
      step(mk(cisu_pkg::OP_PUSH16, x), 1'h0);
      step(mk(cisu_pkg::OP_PUSH8, y), 1'h0);
      idle();
      wb(1'h0, 5'h14, 32'h0);
      chk("spUp", rdq[3:0], 4'h1);
      step(mk(cisu_pkg::OP_POP, 16'h0), 1'h0);
      idle();
      chk("pop8", aluOperand, {p, y[7:0]});
      a = rnd();
      step(mk(cisu_pkg::OP_PUSH16, a), 1'h0);
      step(mk(cisu_pkg::OP_POP, 16'h0), 1'h0);
      idle();
      chk("popNew", aluOperand, a);
      step(mk(cisu_pkg::OP_POP, 16'h0), 1'h0);
      idle();
      chk("popOld", aluOperand, x);
      wb(1'h0, 5'h14, 32'h0);
      chk("spDown", rdq[3:0], 4'hf);
      wb(1'h1, 5'h14, 32'h3);
      wb(1'h0, 5'h14, 32'h0);
      chk("spWrite", rdq[3:0], 4'h3);
      // the sequencer sets the pointer; only the low four bits count
      step(mk(cisu_pkg::OP_SETSP, 16'hfff9), 1'h0);
      idle();
      wb(1'h0, 5'h14, 32'h0);
      chk("spSet", rdq[3:0], 4'h9);
      step(mk(cisu_pkg::OP_PUSH16, x), 1'h0);
      step(mk(cisu_pkg::OP_RET, 16'h0), 1'h0);
      idle();
      chk("retJump", jumpAddr, x);
      step(mk(cisu_pkg::OP_CALL, y), 1'h0);
      step(mk(cisu_pkg::OP_RET, 16'h0), 1'h0);
      idle();
      chk("callRet", jumpAddr, y);
      step(mk(cisu_pkg::OP_JUMP8, y), 1'h0);
      idle();
      chk("jump8", {jumpValid, jumpAddr}, {1'h1, p, y[7:0]});
      wb(1'h1, 5'h04, 32'h2);
      step(mk(cisu_pkg::OP_PUSH16, y), 1'h0);
      step(mk(cisu_pkg::OP_POPI, 16'h0), 1'h0);
      idle();
      chk("popi", {inService, aluOperand}, {1'h0, y});
      // every return condition, with the flags both set and clear
      for (c = 0; c < 5; c++)
         for (f = 0; f < 2; f++) begin
            a = rnd();
            wb(1'h1, 5'h04, 32'h2);
            step(mk(cisu_pkg::OP_PUSH16, a), 1'h0);
            step(mk(cisu_pkg::OP_RETI_COND, 16'h0, c[2:0], {3{f[0]}}), 1'h0);
            idle();
            chk("condJump", jumpValid, condExp(c, f));
            chk("condIns", inService, !condExp(c, f));
            if (condExp(c, f))
               chk("condAddr", jumpAddr, a);
         end
      endOfTest();
   end
endmodule
`default_nettype wire
